// ===== logic/xsd_pkg.sv
// Shared constants and types for the expansion slot host side.
// Behaviour
// (R1) Host drives a latched 24-bit copy of the address on the slot.
// (R2) 32-bit buffered data bus carries byte, half-word and word transfers.
// (R3) Byte-width line low for byte access, high otherwise; ignored during DMA.
// (R4) Read-not-write high during reads, low during writes.
// (R5) Separate active-low read and write strobes time every transfer.
// (R6) Active-low extended-space select asserted for every extended-space access.
// (R7) Card may pull ready low; host holds strobe until ready returns high. The host ignores ready during DMA cycles.
// (R8) Request high from card, acknowledge low from host, terminal flag on last.
// (R9) Select held low at least 427 ns for type A, 175 ns for type C.
// (R10) Upper sixteen data lines driven except during DMA and extended reads; the host also drives them during DMA writes.
// (R11) Card enables upper data drivers only during extended and DMA reads.
// (R12) DMA signalling serviced only on slots 0 and 1.
// (R13) Card logic should not depend on the bus clock or its edges.
// (R14) Card should synchronise all incoming bus controls to its own clock.
// (R15) Card asserts ready soon after cycle start, holds it until done.
// (R16) Each slot has 16MB extended space, byte or word addressable.
// (R17) Select falls before the strobe and rises only after the strobe.
// (R18) Card decodes only while select low, latches write data on strobe rise.
package xsd_pkg;

  // Link clock period assumed for timing counts, in picoseconds
  localparam int LINK_PERIOD_PS = 12000;

  // Documented minimum times in nanoseconds, type A and type C
  localparam int ADDR_SETUP_NS = 10;
  localparam int ADDR_HOLD_NS  = 10;
  localparam int DATA_HOLD_NS  = 25;
  localparam int SEL_MIN_A_NS  = 427;
  localparam int SEL_MIN_C_NS  = 175;
  localparam int LEAD_A_NS     = 80;
  localparam int LEAD_C_NS     = 15;
  localparam int STROBE_A_NS   = 240;
  localparam int STROBE_C_NS   = 115;
  localparam int TRAIL_A_NS    = 80;
  localparam int TRAIL_C_NS    = 15;

  // Least time rounded up to link cycles, never below one
  function automatic logic [7:0] xsd_ceil_cyc(input int ns);
    int c;
    c = (ns * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    if (c < 1) c = 1;
    return c[7:0];
  endfunction : xsd_ceil_cyc

  localparam logic [7:0] SETUP_CYC   = xsd_ceil_cyc(ADDR_SETUP_NS);
  localparam logic [7:0] HOLD_CYC    = xsd_ceil_cyc(ADDR_HOLD_NS);
  localparam logic [7:0] SEL_A_CYC   = xsd_ceil_cyc(SEL_MIN_A_NS);
  localparam logic [7:0] SEL_C_CYC   = xsd_ceil_cyc(SEL_MIN_C_NS);
  localparam logic [7:0] LEAD_A_CYC  = xsd_ceil_cyc(LEAD_A_NS);
  localparam logic [7:0] LEAD_C_CYC  = xsd_ceil_cyc(LEAD_C_NS);
  localparam logic [7:0] STB_A_CYC   = xsd_ceil_cyc(STROBE_A_NS);
  localparam logic [7:0] STB_C_CYC   = xsd_ceil_cyc(STROBE_C_NS);
  localparam logic [7:0] TRAIL_A_CYC = xsd_ceil_cyc(TRAIL_A_NS);
  localparam logic [7:0] TRAIL_C_CYC = xsd_ceil_cyc(TRAIL_C_NS);
  // Write data must hold after strobe rise across trail plus hold
  localparam logic [7:0] WR_HOLD_CYC = xsd_ceil_cyc(DATA_HOLD_NS);

  localparam int ADDR_W    = 24;
  localparam int DATA_W    = 32;
  localparam int HALF_W    = 16;
  localparam int DMA_SLOTS = 2;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {XSD_BYTE, XSD_HALF, XSD_WORD} xsd_width_t;
  typedef enum logic {XSD_TYPE_A, XSD_TYPE_C} xsd_speed_t;

  // One queued bus request
  typedef struct packed {
    logic              read;
    logic              dma;
    xsd_speed_t        speed;
    xsd_width_t        width;
    logic              slot;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } xsd_cmd_t;

  typedef enum {
    ST_IDLE, ST_WAIT_REQ, ST_SETUP, ST_LEAD, ST_STROBE, ST_TRAIL, ST_HOLD
  } xsd_state_t;

endpackage : xsd_pkg

// ===== logic/xsd_host.sv
// Host end of the slot extended-space and DMA bus, with command FIFO.
`timescale 1ns/10ps

// Synchronous FIFO with valid/ready on both sides
module xsd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) mem[wrPtr] <= inData;
  end

  // Pointers and count
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + AW'(1);
      if (pop)  rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : xsd_fifo

module xsd_host
  import xsd_pkg::*;
(
  // System clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Link clock for the bus-facing logic
  input  wire logic                 link_clk,
  // Command port
  input  wire logic                 cmdValid,
  output logic                      cmdReady,
  input  wire xsd_cmd_t             cmd,
  // Completion port
  output logic                      rspValid,
  output logic [DATA_W-1:0]         rspData,
  // Slot address and qualifiers
  output logic [ADDR_W-1:0]         latched_addr,
  output logic                      byte_width_n,
  output logic                      read_not_write,
  output logic                      write_strobe_n,
  output logic                      read_strobe_n,
  output logic                      ext_space_select_n,
  input  wire logic                 ready_n,
  // Buffered data bus, split lanes
  input  wire logic [DATA_W-1:0]    buffered_data_in,
  output logic [DATA_W-1:0]         buffered_data_out,
  output logic                      dataLoOe_n,
  output logic                      dataHiOe_n,
  // DMA lines for slots 0 and 1
  input  wire logic [DMA_SLOTS-1:0] transfer_request,
  output logic [DMA_SLOTS-1:0]      transfer_grant_n,
  output logic [DMA_SLOTS-1:0]      final_transfer_flag
);

  // ---------------- System clock domain ----------------
  xsd_cmd_t fifoOut;
  logic     fifoValid;
  logic     fifoPop;
  xsd_cmd_t cmdHold;
  logic     busy;
  logic     reqTog;
  logic     ackSync1;
  logic     ackSync2;
  logic     ackSeen;
  logic     ackTog;
  logic [DATA_W-1:0] linkData;

  // Command FIFO; drains only when no transfer is outstanding
  xsd_fifo #(
    .WIDTH ($bits(xsd_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inValid  (cmdValid),
    .inReady  (cmdReady),
    .inData   (cmd),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoOut)
  );

  assign fifoPop = fifoValid && !busy;

  // Hold the command stable across the crossing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmdHold <= '0;
    end else if (fifoPop) begin
      cmdHold <= fifoOut;
    end
  end

  // Request toggle and outstanding flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reqTog <= 1'b0;
      busy   <= 1'b0;
    end else if (fifoPop) begin
      reqTog <= ~reqTog;
      busy   <= 1'b1;
    end else if (ackSync2 != ackSeen) begin
      busy   <= 1'b0;
    end
  end

  // Acknowledge toggle synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ackSync1 <= 1'b0;
      ackSync2 <= 1'b0;
      ackSeen  <= 1'b0;
    end else begin
      ackSync1 <= ackTog;
      ackSync2 <= ackSync1;
      ackSeen  <= ackSync2;
    end
  end

  // Completion pulse with data read back from the slot
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rspValid <= 1'b0;
      rspData  <= '0;
    end else begin
      rspValid <= (ackSync2 != ackSeen);
      if (ackSync2 != ackSeen) rspData <= linkData;
    end
  end

  // ---------------- Link clock domain ----------------
  logic                 linkRst1;
  logic                 linkRstN;
  logic                 reqSync1;
  logic                 reqSync2;
  logic                 reqSeen;
  logic                 rdySync1;
  logic                 rdySync2;
  logic [DMA_SLOTS-1:0] drqSync1;
  logic [DMA_SLOTS-1:0] drqSync2;
  logic [DATA_W-1:0]    datSync1;
  logic [DATA_W-1:0]    datSync2;
  xsd_cmd_t             cur;
  xsd_state_t           state;
  xsd_state_t           next_state;
  logic [7:0]           phaseCnt;
  logic [7:0]           selCnt;
  logic [7:0]           leadCyc;
  logic [7:0]           stbCyc;
  logic [7:0]           trailCyc;
  logic [7:0]           selCyc;
  logic [7:0]           holdCyc;
  logic                 newReq;
  logic                 active;

  // Reset and inputs pass two flops before use [R14]
  always_ff @(posedge link_clk) begin
    linkRst1 <= rst_n;
    linkRstN <= linkRst1;
    reqSync1 <= reqTog;
    reqSync2 <= reqSync1;
    rdySync1 <= ready_n;
    rdySync2 <= rdySync1;
    drqSync1 <= transfer_request;
    drqSync2 <= drqSync1;
    datSync1 <= buffered_data_in;
    datSync2 <= datSync1;
  end

  assign newReq = (reqSync2 != reqSeen);

  // Phase lengths for the current speed
  assign leadCyc  = (cur.speed == XSD_TYPE_A) ? LEAD_A_CYC  : LEAD_C_CYC;
  assign stbCyc   = (cur.speed == XSD_TYPE_A) ? STB_A_CYC   : STB_C_CYC;
  assign trailCyc = (cur.speed == XSD_TYPE_A) ? TRAIL_A_CYC : TRAIL_C_CYC;
  assign selCyc   = (cur.speed == XSD_TYPE_A) ? SEL_A_CYC   : SEL_C_CYC; // [R9]
  assign holdCyc  = (cur.read || WR_HOLD_CYC <= trailCyc + HOLD_CYC) ? HOLD_CYC
                    : 8'(WR_HOLD_CYC - trailCyc);

  // Cycle sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (newReq) next_state = cmdHold.dma ? ST_WAIT_REQ : ST_SETUP;
      end
      ST_WAIT_REQ: begin
        if (drqSync2[cur.slot]) next_state = ST_LEAD; // [R8]
      end
      ST_SETUP: begin
        if (phaseCnt >= SETUP_CYC - 8'h01) next_state = ST_LEAD;
      end
      ST_LEAD: begin
        if (phaseCnt >= leadCyc - 8'h01) next_state = ST_STROBE; // [R17]
      end
      ST_STROBE: begin
        // Card stretch only applies to extended-space cycles
        if (phaseCnt >= stbCyc - 8'h01 && (cur.dma || rdySync2)) begin // [R7]
          next_state = ST_TRAIL;
        end
      end
      ST_TRAIL: begin
        if (phaseCnt >= trailCyc - 8'h01 && selCnt >= selCyc - 8'h01) begin // [R9] [R17]
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (phaseCnt >= holdCyc - 8'h01) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State and phase counter
  always_ff @(posedge link_clk) begin
    if (!linkRstN) begin
      state    <= ST_IDLE;
      phaseCnt <= 8'h00;
    end else begin
      state    <= next_state;
      phaseCnt <= (next_state != state) ? 8'h00 : phaseCnt + 8'h01;
    end
  end

  // Select or grant low time
  assign active = (state == ST_LEAD) || (state == ST_STROBE) || (state == ST_TRAIL);
  always_ff @(posedge link_clk) begin
    if (!linkRstN) selCnt <= 8'h00;
    else if (active) selCnt <= selCnt + 8'h01;
    else selCnt <= 8'h00;
  end

  // Capture the command when a new one arrives
  always_ff @(posedge link_clk) begin
    if (!linkRstN) begin
      cur     <= '0;
      reqSeen <= 1'b0;
    end else if (state == ST_IDLE && newReq) begin
      cur     <= cmdHold;
      reqSeen <= reqSync2;
    end
  end

  // Address and qualifiers, held for the whole cycle
  always_ff @(posedge link_clk) begin
    if (!linkRstN) begin
      latched_addr   <= '0;
      byte_width_n   <= 1'b1;
      read_not_write <= 1'b1;
    end else if (state == ST_IDLE && newReq) begin
      latched_addr   <= cmdHold.addr; // [R1] [R16]
      byte_width_n   <= cmdHold.dma ? 1'b1 : (cmdHold.width != XSD_BYTE); // [R3]
      read_not_write <= cmdHold.read; // [R4]
    end else if (state == ST_IDLE) begin
      read_not_write <= 1'b1;
    end
  end

  // Extended-space select
  always_ff @(posedge link_clk) begin
    if (!linkRstN) begin
      ext_space_select_n <= 1'b1;
    end else if (state == ST_SETUP && next_state == ST_LEAD) begin
      ext_space_select_n <= 1'b0; // [R6]
    end else if (state == ST_TRAIL && next_state == ST_HOLD) begin
      ext_space_select_n <= 1'b1; // [R17]
    end
  end

  // DMA grant and terminal flag, slots 0 and 1 only
  always_ff @(posedge link_clk) begin
    if (!linkRstN) begin
      transfer_grant_n    <= '1;
      final_transfer_flag <= '0;
    end else if (state == ST_WAIT_REQ && next_state == ST_LEAD) begin
      transfer_grant_n[cur.slot]    <= 1'b0; // [R8] [R12]
      final_transfer_flag[cur.slot] <= cur.last; // [R8]
    end else if (state == ST_TRAIL && next_state == ST_HOLD) begin
      transfer_grant_n    <= '1;
      final_transfer_flag <= '0;
    end
  end

  // Read and write strobes
  always_ff @(posedge link_clk) begin
    if (!linkRstN) begin
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
    end else if (state == ST_LEAD && next_state == ST_STROBE) begin
      read_strobe_n  <= ~cur.read; // [R5]
      write_strobe_n <= cur.read; // [R5]
    end else if (state == ST_STROBE && next_state == ST_TRAIL) begin
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
    end
  end

  // Data drive: upper half released only for reads
  always_ff @(posedge link_clk) begin
    if (!linkRstN) begin
      buffered_data_out <= '0;
      dataLoOe_n        <= 1'b1;
      dataHiOe_n        <= 1'b0;
    end else if (state == ST_IDLE && newReq) begin
      buffered_data_out <= cmdHold.data; // [R2]
      dataLoOe_n        <= cmdHold.read;
      dataHiOe_n        <= cmdHold.read; // [R10] [R11]
    end else if (state == ST_HOLD && next_state == ST_IDLE) begin
      dataLoOe_n <= 1'b1;
      dataHiOe_n <= 1'b0; // [R10]
    end
  end

  // Read data taken from the synchroniser after strobe rise
  always_ff @(posedge link_clk) begin
    if (!linkRstN) begin
      linkData <= '0;
    end else if (state == ST_TRAIL && phaseCnt == 8'h01 && cur.read) begin
      linkData <= datSync2; // [R2]
    end
  end

  // Completion toggle back to the system domain
  always_ff @(posedge link_clk) begin
    if (!linkRstN) ackTog <= 1'b0;
    else if (state == ST_HOLD && next_state == ST_IDLE) ackTog <= ~ackTog;
  end

endmodule : xsd_host

// ===== verification/xsd_host_checker.sv
// Bus-side assertions for the slot host
`timescale 1ns/10ps
module xsd_host_checker
  import xsd_pkg::*;
(
  // Link clock and reset
  input wire logic                 link_clk,
  input wire logic                 rst_n,
  // Slot lines
  input wire logic [ADDR_W-1:0]    latched_addr,
  input wire logic                 byte_width_n,
  input wire logic                 read_not_write,
  input wire logic                 write_strobe_n,
  input wire logic                 read_strobe_n,
  input wire logic                 ext_space_select_n,
  input wire logic                 ready_n,
  input wire logic                 dataLoOe_n,
  input wire logic                 dataHiOe_n,
  input wire logic [DMA_SLOTS-1:0] transfer_request,
  input wire logic [DMA_SLOTS-1:0] transfer_grant_n,
  input wire logic [DMA_SLOTS-1:0] final_transfer_flag
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  logic       stbLow;
  logic [7:0] selLow = 8'h00;
  // Either strobe active
  assign stbLow = !(read_strobe_n && write_strobe_n);
  // Cycles the select has stayed low
  always_ff @(posedge link_clk) begin
    selLow <= ext_space_select_n ? 8'h00 : selLow + 8'h01;
  end
  // Card stretching an extended cycle
  sequence s_held;
    (!ready_n && stbLow && !ext_space_select_n)[*3];
  endsequence
  // Strobe released inside an extended cycle
  sequence s_stb_end;
    $fell(stbLow) ##0 (transfer_grant_n == 2'b11);
  endsequence
  a_ready_stretch: assert property (s_held |=> stbLow)
    else $error("strobe released while ready low");
  a_sel_first: assert property ($fell(ext_space_select_n) |-> !stbLow)
    else $error("strobe active before select");
  a_sel_after: assert property (s_stb_end |-> !ext_space_select_n)
    else $error("select released with strobe");
  a_strobe_qual: assert property (stbLow |-> !ext_space_select_n || transfer_grant_n != 2'b11)
    else $error("strobe without select or grant");
  a_rnw_dir: assert property (stbLow |-> read_not_write == !read_strobe_n && write_strobe_n == !read_strobe_n)
    else $error("direction line wrong");
  a_hi_lane: assert property (stbLow |-> dataHiOe_n == !read_strobe_n && dataLoOe_n == write_strobe_n)
    else $error("data lane enables wrong");
  a_sel_width: assert property ($rose(ext_space_select_n) |-> selLow >= SEL_C_CYC)
    else $error("select too short");
  a_addr_stable: assert property (!ext_space_select_n && $past(!ext_space_select_n) |-> $stable(latched_addr) && $stable(byte_width_n))
    else $error("address moved under select");
  a_dma_quiet: assert property (transfer_grant_n != 2'b11 |-> byte_width_n && ext_space_select_n)
    else $error("select or width during grant");
  a_flag_grant: assert property ((final_transfer_flag & transfer_grant_n) == 2'b00)
    else $error("terminal flag outside grant");
  a_grant_req0: assert property ($fell(transfer_grant_n[0]) |-> $past(transfer_request[0], 2))
    else $error("grant 0 without request");
  a_grant_req1: assert property ($fell(transfer_grant_n[1]) |-> $past(transfer_request[1], 2))
    else $error("grant 1 without request");
endmodule : xsd_host_checker

// ===== verification/xsd_card_model.sv
// Behavioural card logic in a slot
`timescale 1ns/10ps
module xsd_card_model
  import xsd_pkg::*;
(
  // Card clock
  input wire logic                  cardClk,
  // Lines from the host
  input wire logic [ADDR_W-1:0]     latched_addr,
  input wire logic                  byte_width_n,
  input wire logic                  read_strobe_n,
  input wire logic                  write_strobe_n,
  input wire logic                  ext_space_select_n,
  input wire logic [DATA_W-1:0]     buffered_data_out,
  input wire logic [DMA_SLOTS-1:0]  transfer_grant_n,
  input wire logic [DMA_SLOTS-1:0]  final_transfer_flag,
  // Lines to the host
  output logic                      ready_n,
  output logic [DATA_W-1:0]         buffered_data_in,
  output logic [DMA_SLOTS-1:0]      transfer_request,
  // Bench control and observation
  input wire logic [7:0]            stretch,
  input wire logic [DMA_SLOTS-1:0]  reqOn,
  output logic [ADDR_W-1:0]         lastAddr,
  output logic [DATA_W-1:0]         lastWr,
  output logic                      lastBw,
  output logic [7:0]                selWidth,
  output logic [7:0]                stbWidth,
  output logic [DMA_SLOTS-1:0]      flagSeen
);
  logic [1:0] stbSync = 2'b11;
  logic [7:0] rdyCnt  = 8'h00;
  logic [7:0] selCnt  = 8'h00;
  logic [7:0] stbCnt  = 8'h00;
  logic [2:0] holdCnt = 3'h0;
  logic       wrPrev  = 1'b1;
  // Quiet state at start
  initial begin
    {ready_n, buffered_data_in, transfer_request, flagSeen} = {1'b1, 32'h0, 2'h0, 2'h0};
    {selWidth, stbWidth} = 16'h0;
  end
  // Strobes brought onto the card clock
  always @(posedge cardClk) begin
    stbSync <= {stbSync[0], read_strobe_n & write_strobe_n};
  end
  // Ready held low for the asked stretch, extended cycles only
  always @(posedge cardClk) begin
    if (stbSync == 2'b10 && !ext_space_select_n) rdyCnt <= stretch;
    else if (rdyCnt != 8'h00) rdyCnt <= rdyCnt - 8'h01;
    ready_n <= (rdyCnt == 8'h00);
  end
  // Read data under the read strobe, held five cycles after release, then a moving pattern
  always @(posedge cardClk) begin
    if (!read_strobe_n) begin
      buffered_data_in <= {8'h5a, latched_addr};
      holdCnt <= 3'h5;
    end else if (holdCnt != 3'h0) holdCnt <= holdCnt - 3'h1;
    else buffered_data_in <= ~buffered_data_in;
  end
  // Write latch at strobe rise and cycle measurements
  always @(posedge cardClk) begin
    wrPrev <= write_strobe_n;
    if (write_strobe_n && !wrPrev) lastWr <= buffered_data_out;
    if (!ext_space_select_n) {lastAddr, lastBw} <= {latched_addr, byte_width_n};
    selCnt <= ext_space_select_n ? 8'h00 : selCnt + 8'h01;
    if (ext_space_select_n && selCnt != 8'h00) selWidth <= selCnt;
    stbCnt <= (read_strobe_n & write_strobe_n) ? 8'h00 : stbCnt + 8'h01;
    if ((read_strobe_n & write_strobe_n) && stbCnt != 8'h00) stbWidth <= stbCnt;
    flagSeen <= flagSeen | (final_transfer_flag & ~transfer_grant_n);
  end
  // Request raised on demand, dropped once granted
  always @(posedge cardClk) begin
    transfer_request <= (transfer_request | reqOn) & transfer_grant_n;
  end
endmodule : xsd_card_model

// ===== verification/test_expansion_slot_ext_space_dma_port.sv
// Self-checking bench for the slot host
`timescale 1ns/10ps
module test_expansion_slot_ext_space_dma_port;
  import xsd_pkg::*;
  logic ref_clk = 1'b0, link_clk = 1'b0, rst_n, cmdValid, cmdReady, rspValid;
  logic byte_width_n, read_not_write, write_strobe_n, read_strobe_n;
  logic ext_space_select_n, ready_n, dataLoOe_n, dataHiOe_n, lastBw;
  logic [ADDR_W-1:0] latched_addr, lastAddr;
  logic [DATA_W-1:0] rspData, bdIn, bdOut, lastWr;
  logic [1:0]        req, grant_n, flag, reqOn, flagSeen;
  logic [7:0]        stretch, selWidth, stbWidth;
  xsd_cmd_t          cmd, c;
  int fails = 0, checked = 0, rspCnt = 0, n;
  logic sawFull = 1'b0;
  // Clocks, link offset in phase
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #3.1;
    forever #6 link_clk = ~link_clk;
  end
  xsd_host u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd), .rspValid(rspValid),
    .rspData(rspData), .latched_addr(latched_addr), .byte_width_n(byte_width_n),
    .read_not_write(read_not_write), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .ext_space_select_n(ext_space_select_n),
    .ready_n(ready_n), .buffered_data_in(bdIn), .buffered_data_out(bdOut),
    .dataLoOe_n(dataLoOe_n), .dataHiOe_n(dataHiOe_n), .transfer_request(req),
    .transfer_grant_n(grant_n), .final_transfer_flag(flag));
  xsd_card_model u_card (.cardClk(link_clk), .latched_addr(latched_addr),
    .byte_width_n(byte_width_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .ext_space_select_n(ext_space_select_n),
    .buffered_data_out(bdOut), .transfer_grant_n(grant_n),
    .final_transfer_flag(flag), .ready_n(ready_n), .buffered_data_in(bdIn),
    .transfer_request(req), .stretch(stretch), .reqOn(reqOn), .lastAddr(lastAddr),
    .lastWr(lastWr), .lastBw(lastBw), .selWidth(selWidth), .stbWidth(stbWidth),
    .flagSeen(flagSeen));
  // Completion count and refusal watch
  always @(posedge ref_clk) begin
    if (rspValid === 1'b1) rspCnt++;
    if (cmdValid === 1'b1 && cmdReady === 1'b0) sawFull = 1'b1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // Offer one command, held until taken
  task automatic send(input xsd_cmd_t x, input logic drop);
    logic rdy;
    int k;
    rdy = 1'b0;
    k = 0;
    cmd <= x;
    cmdValid <= 1'b1;
    while (!rdy) begin
      #1 rdy = (cmdReady === 1'b1);
      @(posedge ref_clk);
      if (++k > 300) begin
        fails++;
        results();
      end
    end
    if (drop) cmdValid <= 1'b0;
  endtask : send
  task automatic wait_rsp(input int t);
    int k;
    k = 0;
    while (rspCnt < t) begin
      @(posedge ref_clk);
      if (++k > 5000) begin
        fails++;
        results();
      end
    end
    @(posedge ref_clk);
  endtask : wait_rsp
  function automatic logic [31:0] exp_rd(input logic [23:0] a);
    return {8'h5a, a};
  endfunction : exp_rd
  // Main sequence
  initial begin
    {rst_n, cmdValid, cmd, stretch, reqOn} = '0;
    void'($urandom(32'hcb5e0518));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    // Extended cycles: each width, both speeds, stretched and not
    for (int i = 0; i < 12; i++) begin
      c = '0;
      c.read = i[0];
      c.speed = xsd_speed_t'(i[1]);
      c.width = xsd_width_t'(2'(i % 3));
      c.addr = (i == 0) ? 24'hffffff : 24'($urandom);
      c.data = $urandom;
      stretch <= (i > 7) ? 8'h28 : 8'h00;
      n = rspCnt;
      send(c, 1'b1);
      wait_rsp(n + 1);
      check(lastAddr, c.addr, "address");
      check(lastBw, c.width != XSD_BYTE, "byte width");
      check(selWidth >= (c.speed ? SEL_C_CYC : SEL_A_CYC), 1, "select width");
      check(stbWidth >= (i > 7 ? 8'h28 : (c.speed ? STB_C_CYC : STB_A_CYC)), 1, "strobe width");
      if (c.read) check(rspData, exp_rd(c.addr), "read data");
      else check(lastWr, c.data, "write data");
    end
    // DMA reads on both slots, then a write, flag on slot 1 only
    for (int i = 0; i < 3; i++) begin
      c = '0;
      {c.dma, c.read, c.slot, c.last} = {1'b1, i < 2, i[0], i == 1};
      c.speed = xsd_speed_t'(i[1]);
      c.addr = 24'($urandom);
      c.data = $urandom;
      reqOn <= i[0] ? 2'b10 : 2'b01;
      n = rspCnt;
      send(c, 1'b1);
      repeat (10) @(posedge ref_clk);
      reqOn <= 2'b00;
      wait_rsp(n + 1);
      if (c.read) check(rspData, exp_rd(c.addr), "dma read");
      else check(lastWr, c.data, "dma write");
    end
    check(flagSeen, 2'b10, "terminal flag");
    // Queue filled back to back until refused
    n = rspCnt;
    for (int k = 0; k < 6; k++) begin
      c = '0;
      c.addr = 24'($urandom);
      c.data = $urandom;
      send(c, k == 5);
    end
    wait_rsp(n + 6);
    check(sawFull, 1'b1, "queue refusal");
    check(rspCnt - n, 6, "completions");
    check(lastWr, c.data, "last queued write");
    results();
  end
endmodule : test_expansion_slot_ext_space_dma_port
bind xsd_host xsd_host_checker u_chk (.link_clk, .rst_n, .latched_addr, .byte_width_n,
  .read_not_write, .write_strobe_n, .read_strobe_n, .ext_space_select_n, .ready_n,
  .dataLoOe_n, .dataHiOe_n, .transfer_request, .transfer_grant_n, .final_transfer_flag);
